// *** hdl/srb_core.sv ***
// command interpreter and receive buffer of one serial reader channel
//
// Operation
// R1: host's reset job carries 04 in byte one, 0a in six, 0/02 in eleven.
// R2: reset job restarts reader communication and empties the buffer.
// R3: initialise job clears all buffers, then device reports ready.
// R4: read job with data already held delivers it at once.
// R5: read job without data waits until a reader frame arrives.
// R6: initialise or configuration write cancels a waiting read.
// R7: data-present flag rises when a new reader frame is stored.
// R8: delivery clears data-present unless newer data already arrived.
// R9: full buffer lets new reader bytes overwrite the oldest ones.
// R10: bad or negative reader frame reports error 06 / e2fe01.
// R11: unknown command or bad parameters report 05 / e6fe01.
// R12: job address outside 0000, 0002, ffff reports 0d / e1fe03.
// R13: internal communication failure reports 12 / e4fe8d.
// R14: unfetched data overrun reports 13 / e4fe04, newest frame lost.
// R15: during write jobs old answers are dropped with no error.
// R16: job aborted by initialise or connector loss reports 1f.
// R17: invalid data block number reports e5fe04.
// R18: host sends reader frames as write data, answers come back on reads.
// R19: reads at address 0000 lead with a two-byte valid length.
// R20: host gives address ffff for every send job.
// R21: every job ends done or error with one code, held until next job.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module srb_core #(
  parameter int DEPTH = srb_pkg::BUF_DEPTH,
  parameter logic [7:0] BLK_NUM_MAX = srb_pkg::BLK_NUM_MAX_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire srb_pkg::srb_bus_t bus,
  output logic [31:0] rdata,
  // reader side
  input wire srb_pkg::srb_rx_t rx,
  output srb_pkg::srb_tx_t tx,
  output logic reader_restart,
  // channel events
  input wire logic comm_fail,
  input wire logic bus_unplugged,
  output logic data_present_flag
);

  // the state struct fixes the buffer size, so the parameter must agree
  if (DEPTH != srb_pkg::BUF_DEPTH || DEPTH != (1 << srb_pkg::PTR_W)) begin
    $error("DEPTH must equal the package buffer depth");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by read and write jobs

  function automatic logic addr_valid(input logic [15:0] a);
    addr_valid = (a == srb_pkg::ADDR_LEN) || (a == srb_pkg::ADDR_RAW) ||
      (a == srb_pkg::ADDR_SEND);
  endfunction

  srb_pkg::srb_regs_t s_q;
  srb_pkg::srb_regs_t s_d;

  logic cmd_wr;
  logic [2:0] cmd_kind;
  logic [srb_pkg::PTR_W-1:0] wr_next;
  logic rx_end;

  assign cmd_wr = bus.wr && (bus.addr == srb_pkg::OFF_CMD);
  assign cmd_kind = bus.wdata[2:0];
  assign rx_end = rx.valid && rx.last;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic fin;
    logic deliver;
    logic wait_read;
    srb_pkg::srb_err_t ferr;
    logic [3:0] pidx;
    fin = 1'b0;
    deliver = 1'b0;
    wait_read = 1'b0;
    ferr = srb_pkg::ERR_NONE;
    pidx = bus.wdata[3:0];
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.tx = '0;
    s_d.restart = 1'b0;
    if (comm_fail) begin
      s_d.comm_pend = 1'b1;
    end

    // register reads, answer stands one cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        srb_pkg::OFF_STATUS: begin
          s_d.rdata[srb_pkg::STB_BUSY] = s_q.busy;
          s_d.rdata[srb_pkg::STB_DONE] = s_q.done;
          s_d.rdata[srb_pkg::STB_ERROR] = s_q.error;
          s_d.rdata[srb_pkg::STB_PRESENT] = s_q.present;
          s_d.rdata[srb_pkg::STB_READY] = s_q.ready;
          s_d.rdata[srb_pkg::STB_WMODE] = s_q.write_mode;
        end
        srb_pkg::OFF_ERR: s_d.rdata = s_q.err;
        srb_pkg::OFF_RESLEN: s_d.rdata = {28'h0000000, s_q.res_len};
        srb_pkg::OFF_RXDATA: begin
          // length header first, high byte then low byte
          if (s_q.hdr_left == srb_pkg::HDR_BYTES) begin // R19
            s_d.hdr_left = 2'h1;
          end else if (s_q.hdr_left != 2'h0) begin
            s_d.rdata = {28'h0000000, s_q.res_len}; // R19
            s_d.hdr_left = 2'h0;
          end else if (s_q.rd_ptr != s_q.commit_ptr) begin
            s_d.rdata = {24'h000000, s_q.mem[s_q.rd_ptr]}; // R18
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
          end
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // configuration writes and outgoing reader frames
    if (bus.wr) begin
      case (bus.addr)
        srb_pkg::OFF_ADDR: s_d.job_addr = bus.wdata[15:0];
        srb_pkg::OFF_BLK_NUM: s_d.blk_num = bus.wdata[7:0];
        srb_pkg::OFF_JOB_PARAMETER_BLOCK: begin
          if (pidx < 4'(srb_pkg::JOB_PARAMETER_BLOCK_BYTES)) begin
            s_d.job_parameter_block[pidx] = bus.wdata[15:8];
          end
        end
        srb_pkg::OFF_TX: begin
          s_d.tx.valid = 1'b1; // R18
          s_d.tx.data = bus.wdata[7:0];
          s_d.tx.last = bus.wdata[8];
        end
        default: s_d.tx.valid = 1'b0;
      endcase
    end

    // job start; a new job drops the previous result
    if (cmd_wr && s_q.state == srb_pkg::ST_WAIT) begin
      // only the two cancelling jobs are taken while a read waits
      if (cmd_kind == srb_pkg::JOB_INIT) begin
        fin = 1'b1; // R6
        ferr = srb_pkg::ERR_ABORT; // R16
      end else if (cmd_kind == srb_pkg::JOB_WCFG) begin
        fin = 1'b1; // R6
      end
    end else if (cmd_wr) begin
      fin = 1'b1;
      if (cmd_kind == srb_pkg::JOB_INIT) begin
        ferr = srb_pkg::ERR_NONE;
      end else if (!s_q.ready) begin
        ferr = srb_pkg::ERR_INIT_REQ;
      end else begin
        case (cmd_kind)
          srb_pkg::JOB_RESET: begin
            if (s_q.job_parameter_block[srb_pkg::PRM_IDX_ID] != srb_pkg::PRM_VAL_ID ||
                s_q.job_parameter_block[srb_pkg::PRM_IDX_SIX] != srb_pkg::PRM_VAL_SIX ||
                (s_q.job_parameter_block[srb_pkg::PRM_IDX_OPT] != srb_pkg::PRM_OPT_A &&
                 s_q.job_parameter_block[srb_pkg::PRM_IDX_OPT] != srb_pkg::PRM_OPT_B)) begin
              ferr = srb_pkg::ERR_CMD; // R11
            end
          end
          srb_pkg::JOB_READ: begin
            if (!addr_valid(s_q.job_addr) ||
                s_q.job_addr == srb_pkg::ADDR_SEND) begin
              ferr = srb_pkg::ERR_ADDR; // R12
            end else if (s_q.blk_num > BLK_NUM_MAX) begin
              ferr = srb_pkg::ERR_BLK_NUM; // R17
            end else if (s_q.comm_pend || s_q.nak_pend || s_q.ovf_pend) begin
              ferr = srb_pkg::ERR_NONE;
            end else if (s_q.present) begin
              deliver = 1'b1; // R4
            end else begin
              fin = 1'b0;
              wait_read = 1'b1; // R5
            end
          end
          srb_pkg::JOB_WRITE: begin
            if (!addr_valid(s_q.job_addr)) begin
              ferr = srb_pkg::ERR_ADDR; // R12
            end else if (s_q.job_addr != srb_pkg::ADDR_SEND) begin
              ferr = srb_pkg::ERR_CMD; // R11
            end else if (s_q.blk_num > BLK_NUM_MAX) begin
              ferr = srb_pkg::ERR_BLK_NUM; // R17
            end
          end
          srb_pkg::JOB_WCFG: ferr = srb_pkg::ERR_NONE;
          default: ferr = srb_pkg::ERR_CMD; // R11
        endcase
      end
    end else if (s_q.state == srb_pkg::ST_WAIT) begin
      // a waiting read ends on an error event or on fresh data
      if (bus_unplugged) begin
        fin = 1'b1;
        ferr = srb_pkg::ERR_ABORT; // R16
      end else if (s_q.comm_pend || s_q.nak_pend || s_q.ovf_pend) begin
        fin = 1'b1;
      end else if (s_q.present) begin
        fin = 1'b1;
        deliver = 1'b1; // R5
      end
    end

    // read jobs that finish on a latched reader fault
    if (fin && !deliver && ferr == srb_pkg::ERR_NONE &&
        (s_q.state == srb_pkg::ST_WAIT || cmd_kind == srb_pkg::JOB_READ) &&
        !(cmd_wr && s_q.state == srb_pkg::ST_WAIT) &&
        !(cmd_wr && (!s_q.ready || cmd_kind != srb_pkg::JOB_READ))) begin
      if (s_q.comm_pend) begin
        ferr = srb_pkg::ERR_COMM; // R13
        s_d.comm_pend = comm_fail;
      end else if (s_q.nak_pend) begin
        ferr = srb_pkg::ERR_NAK; // R10
        s_d.nak_pend = 1'b0;
      end else if (s_q.ovf_pend) begin
        ferr = srb_pkg::ERR_OVF; // R14
        s_d.ovf_pend = 1'b0;
      end
    end

    if (cmd_wr) begin
      s_d.done = 1'b0;
      s_d.error = 1'b0;
      s_d.err = srb_pkg::ERR_NONE;
    end
    if (wait_read) begin
      s_d.state = srb_pkg::ST_WAIT;
      s_d.busy = 1'b1;
      s_d.write_mode = 1'b0;
    end
    if (fin) begin
      // exactly one ending per job, held until the next job
      s_d.state = srb_pkg::ST_IDLE; // R21
      s_d.busy = 1'b0;
      s_d.error = (ferr != srb_pkg::ERR_NONE);
      s_d.done = (ferr == srb_pkg::ERR_NONE);
      s_d.err = ferr;
    end
    if (deliver) begin
      s_d.res_len = s_q.commit_ptr - s_d.rd_ptr;
      s_d.hdr_left = (s_q.job_addr == srb_pkg::ADDR_LEN) ?
        srb_pkg::HDR_BYTES : 2'h0; // R19
      s_d.present = 1'b0; // R8
      s_d.write_mode = 1'b0;
    end
    if (cmd_wr && cmd_kind == srb_pkg::JOB_WRITE && !fin) begin
      s_d.write_mode = 1'b0;
    end else if (cmd_wr && cmd_kind == srb_pkg::JOB_WRITE &&
        s_q.state == srb_pkg::ST_IDLE && s_q.ready && !s_d.error) begin
      s_d.write_mode = 1'b1; // R15
    end

    // initialise jobs, and reset jobs that end done, empty the buffer
    if (cmd_wr && (cmd_kind == srb_pkg::JOB_INIT ||
        (cmd_kind == srb_pkg::JOB_RESET && s_d.done))) begin
      s_d.rd_ptr = s_q.wr_ptr; // R2 R3
      s_d.commit_ptr = s_q.wr_ptr;
      s_d.present = 1'b0;
      s_d.hdr_left = 2'h0;
      s_d.res_len = '0;
      if (cmd_kind == srb_pkg::JOB_INIT) begin
        s_d.ready = 1'b1; // R3
        s_d.nak_pend = 1'b0;
        s_d.ovf_pend = 1'b0;
        s_d.comm_pend = comm_fail;
        s_d.write_mode = 1'b0;
      end else begin
        s_d.restart = 1'b1; // R2
      end
    end

    // reader bytes; the set of the present flag wins over delivery
    if (rx.valid) begin
      s_d.mem[s_q.wr_ptr] = rx.data;
      s_d.wr_ptr = wr_next;
      if (wr_next == s_d.rd_ptr) begin
        // full: drop the oldest byte rather than stall the reader
        if (s_d.rd_ptr == s_d.commit_ptr) begin
          s_d.commit_ptr = s_d.commit_ptr + 1'b1;
        end
        s_d.rd_ptr = s_d.rd_ptr + 1'b1; // R9
      end
      if (rx.last) begin
        if (rx.bad) begin
          s_d.wr_ptr = s_d.commit_ptr;
          s_d.nak_pend = 1'b1; // R10
        end else if (s_d.write_mode) begin
          s_d.rd_ptr = s_d.commit_ptr; // R15
          s_d.commit_ptr = wr_next;
          s_d.present = 1'b1;
        end else if (s_d.present) begin
          // a delivery in this cycle frees the slot for this frame
          s_d.wr_ptr = s_d.commit_ptr; // R14
          s_d.ovf_pend = 1'b1;
        end else begin
          s_d.commit_ptr = wr_next;
          s_d.present = 1'b1; // R7 R8
        end
      end
    end
  end

  assign wr_next = s_q.wr_ptr + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= srb_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign tx = s_q.tx;
  assign reader_restart = s_q.restart;
  assign data_present_flag = s_q.present; // R7

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence read_waiting;
    s_q.state == srb_pkg::ST_WAIT;
  endsequence
  sequence cancel_job;
    cmd_wr && (cmd_kind == srb_pkg::JOB_INIT ||
      cmd_kind == srb_pkg::JOB_WCFG);
  endsequence

  a_good_frame_sets: assert property (rx_end && !rx.bad |=> s_q.present) // R7
    else $error("present flag not set after good frame");
  a_fresh_wait_ends: assert property (read_waiting ##0 (s_q.present && // R5
    !cmd_wr && !bus_unplugged && !s_q.comm_pend && !s_q.nak_pend &&
    !s_q.ovf_pend && !rx_end) |=> s_q.done && !s_q.present &&
    s_q.state == srb_pkg::ST_IDLE)
    else $error("waiting read did not deliver");
  a_cancel_read: assert property (read_waiting ##0 cancel_job |=> // R6
    s_q.state == srb_pkg::ST_IDLE ##1 !s_q.busy)
    else $error("waiting read not cancelled");
  // a job or a full buffer moves the commit point, so those are left out
  a_nak_latched: assert property (rx_end && rx.bad && !cmd_wr && // R10
    wr_next != s_q.rd_ptr |=> s_q.nak_pend &&
    s_q.wr_ptr == $past(s_q.commit_ptr))
    else $error("bad frame not discarded");
  a_overrun_drop: assert property (rx_end && !rx.bad && s_q.present && // R14
    !s_q.write_mode && !cmd_wr && s_q.state == srb_pkg::ST_IDLE |=>
    s_q.ovf_pend && s_q.present)
    else $error("overrun not flagged");
  a_addr_error: assert property (cmd_wr && // R12
    cmd_kind == srb_pkg::JOB_READ && s_q.state == srb_pkg::ST_IDLE &&
    s_q.ready && !addr_valid(s_q.job_addr) |=> s_q.error &&
    s_q.err == srb_pkg::ERR_ADDR)
    else $error("bad job address accepted");
  a_init_empties: assert property (cmd_wr && // R3
    cmd_kind == srb_pkg::JOB_INIT && !rx.valid |=> s_q.ready &&
    s_q.rd_ptr == s_q.commit_ptr && !s_q.present)
    else $error("initialise left data behind");
  a_unplug_abort: assert property (read_waiting ##0 (bus_unplugged && // R16
    !cmd_wr) |=> s_q.error && s_q.err.legacy == 8'h1f)
    else $error("unplug did not abort read");
  a_one_ending: assert property (!(s_q.done && s_q.error) && // R21
    (s_q.error == (s_q.err != srb_pkg::ERR_NONE)))
    else $error("job ending not unique");
  a_tx_forward: assert property (bus.wr && // R18
    bus.addr == srb_pkg::OFF_TX |=> tx.valid &&
    tx.data == $past(bus.wdata[7:0]))
    else $error("send byte not forwarded");
  // the second header read answers with the length of the delivery
  a_len_header: assert property (bus.rd && // R19
    bus.addr == srb_pkg::OFF_RXDATA && s_q.hdr_left == 2'h1 |=>
    rdata == {28'h0000000, $past(s_q.res_len)})
    else $error("length header wrong");
  a_full_overwrite: assert property (rx.valid && !rx.last && !bus.rd && // R9
    !cmd_wr && wr_next == s_q.rd_ptr |=>
    s_q.rd_ptr == $past(s_q.rd_ptr) + 1'b1)
    else $error("full buffer not overwritten");

endmodule

// *** pkg/srb_pkg.sv ***
// shared constants, types and carriers of the serial receive buffer block
package srb_pkg;

  // buffer geometry
  localparam int BUF_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int JOB_PARAMETER_BLOCK_BYTES = 12;
  localparam logic [7:0] BLK_NUM_MAX_DEF = 8'h01;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_JOB_PARAMETER_BLOCK = 8'h08;
  localparam logic [7:0] OFF_BLK_NUM = 8'h0c;
  localparam logic [7:0] OFF_TX = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ERR = 8'h18;
  localparam logic [7:0] OFF_RXDATA = 8'h1c;
  localparam logic [7:0] OFF_RESLEN = 8'h20;

  // status word bit positions
  localparam int STB_BUSY = 0;
  localparam int STB_DONE = 1;
  localparam int STB_ERROR = 2;
  localparam int STB_PRESENT = 3;
  localparam int STB_READY = 4;
  localparam int STB_WMODE = 5;

  // job kinds in the command word
  localparam logic [2:0] JOB_INIT = 3'h0;
  localparam logic [2:0] JOB_RESET = 3'h1;
  localparam logic [2:0] JOB_READ = 3'h2;
  localparam logic [2:0] JOB_WRITE = 3'h3;
  localparam logic [2:0] JOB_WCFG = 3'h4;

  // job addresses
  localparam logic [15:0] ADDR_LEN = 16'h0000;
  localparam logic [15:0] ADDR_RAW = 16'h0002;
  localparam logic [15:0] ADDR_SEND = 16'hffff;
  localparam logic [1:0] HDR_BYTES = 2'h2;

  // reset job parameter block checks (zero based byte index)
  localparam logic [3:0] PRM_IDX_ID = 4'h0;
  localparam logic [3:0] PRM_IDX_SIX = 4'h5;
  localparam logic [3:0] PRM_IDX_OPT = 4'ha;
  localparam logic [7:0] PRM_VAL_ID = 8'h04;
  localparam logic [7:0] PRM_VAL_SIX = 8'h0a;
  localparam logic [7:0] PRM_OPT_A = 8'h00;
  localparam logic [7:0] PRM_OPT_B = 8'h02;

  // error code pair: legacy interface byte, profile interface word
  typedef struct packed {
    logic [7:0] legacy;
    logic [23:0] profile;
  } srb_err_t;

  localparam srb_err_t ERR_NONE = {8'h00, 24'h000000};
  localparam srb_err_t ERR_NAK = {8'h06, 24'he2fe01};
  localparam srb_err_t ERR_CMD = {8'h05, 24'he6fe01};
  localparam srb_err_t ERR_ADDR = {8'h0d, 24'he1fe03};
  localparam srb_err_t ERR_COMM = {8'h12, 24'he4fe8d};
  localparam srb_err_t ERR_OVF = {8'h13, 24'he4fe04};
  localparam srb_err_t ERR_INIT_REQ = {8'h18, 24'he6fe05};
  localparam srb_err_t ERR_ABORT = {8'h1f, 24'h000000};
  localparam srb_err_t ERR_BLK_NUM = {8'h05, 24'he5fe04};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } srb_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } srb_bus_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic bad;
  } srb_rx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } srb_tx_t;

  typedef struct packed {
    srb_state_t state;
    logic [BUF_DEPTH-1:0][7:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] commit_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] res_len;
    logic [1:0] hdr_left;
    logic present;
    logic ready;
    logic write_mode;
    logic busy;
    logic done;
    logic error;
    srb_err_t err;
    logic [15:0] job_addr;
    logic [7:0] blk_num;
    logic [JOB_PARAMETER_BLOCK_BYTES-1:0][7:0] job_parameter_block;
    logic nak_pend;
    logic ovf_pend;
    logic comm_pend;
    logic [31:0] rdata;
    srb_tx_t tx;
    logic restart;
  } srb_regs_t;

endpackage

// *** sim/srb_reader_model.sv ***
// behavioural serial reader standing on the far side of the channel
`timescale 1ns/1ps

module srb_reader_model (
  // clock
  clock,
  // reader link
  rx,
  tx
);
  input wire logic clock;
  output srb_pkg::srb_rx_t rx;
  input wire srb_pkg::srb_tx_t tx;

  int tx_count = 0;
  logic [7:0] tx_last_byte = 8'h00;

  initial begin
    rx = '0;
  end

  // job bytes from the host land here, counted for the bench
  always @(posedge clock) begin
    if (tx.valid === 1'b1) begin
      tx_count <= tx_count + 1;
      tx_last_byte <= tx.data;
    end
  end

  // answer frame; gap idle cycles per byte make a slow reader, and an
  // idle line shows the inverse byte, flipping back to the byte itself on every second idle cycle, so a stale copy is never mistaken
  task automatic send(input int n, input logic [7:0] base,
                      input logic bad, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx <= {1'b1, base + 8'(i), i == n - 1, bad && i == n - 1};
      for (int g = 0; g < gap; g++) begin
        @(posedge clock);
        rx <= {1'b0, ~rx.data, 2'b00};
      end
    end
    @(posedge clock);
    rx <= {1'b0, ~rx.data, 2'b00};
  endtask
endmodule

// *** sim/serial_reader_receive_buffer_cmd_bench.sv ***
// self-checking bench of the serial receive buffer command block
`timescale 1ns/1ps

module serial_reader_receive_buffer_cmd_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  srb_pkg::srb_bus_t bus = '0;
  logic [31:0] rdata;
  srb_pkg::srb_rx_t rx;
  srb_pkg::srb_tx_t tx;
  logic reader_restart;
  logic comm_fail = 1'b0;
  logic bus_unplugged = 1'b0;
  logic data_present_flag;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_restart = 0;
  logic [31:0] v;

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 clock = ~clock;

  srb_core dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .rx(rx), .tx(tx), .reader_restart(reader_restart),
    .comm_fail(comm_fail), .bus_unplugged(bus_unplugged),
    .data_present_flag(data_present_flag));
  srb_reader_model rdr (.clock(clock), .rx(rx), .tx(tx));

  // count restart pulses so a stuck or doubled pulse shows up
  always @(posedge clock) begin
    if (reader_restart === 1'b1) begin
      n_restart <= n_restart + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus cycles and judging
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic start(input logic [2:0] k, input logic [15:0] a);
    wr(srb_pkg::OFF_ADDR, {16'h0000, a});
    wr(srb_pkg::OFF_CMD, {29'h0, k});
  endtask

  // poll status until not busy, then judge the outcome and its code
  task automatic finish(input srb_pkg::srb_err_t e);
    logic [31:0] s;
    int i;
    i = 0;
    s = 32'h1;
    while (s[srb_pkg::STB_BUSY] !== 1'b0) begin
      rd(srb_pkg::OFF_STATUS, s);
      i++;
      if (i > 100) begin
        chk("job end", 32'h1, 32'h0);
        end_of_test();
      end
    end
    chk("done", 32'(s[srb_pkg::STB_DONE]), 32'(e == 32'h0));
    chk("error", 32'(s[srb_pkg::STB_ERROR]), 32'(e != 32'h0));
    rd(srb_pkg::OFF_ERR, s);
    chk("error code", s, e);
  endtask

  task automatic job(input logic [2:0] k, input logic [15:0] a,
                     input srb_pkg::srb_err_t e);
    start(k, a);
    finish(e);
  endtask

  task automatic wait_flag();
    int i;
    i = 0;
    #1;
    while (data_present_flag !== 1'b1 && i < 20) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk("present", 32'(data_present_flag), 32'h1);
    if (data_present_flag !== 1'b1) begin
      end_of_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_init();
    job(srb_pkg::JOB_READ, 16'h0, srb_pkg::ERR_INIT_REQ);
    job(srb_pkg::JOB_INIT, 16'h0, srb_pkg::ERR_NONE);
    rd(srb_pkg::OFF_STATUS, v);
    chk("ready", 32'(v[srb_pkg::STB_READY]), 32'h1);
  endtask

  task automatic t_reset();
    int n0;
    n0 = n_restart;
    wr(srb_pkg::OFF_JOB_PARAMETER_BLOCK, 32'h0400);
    wr(srb_pkg::OFF_JOB_PARAMETER_BLOCK, 32'h0a05);
    wr(srb_pkg::OFF_JOB_PARAMETER_BLOCK, 32'h030a);
    job(srb_pkg::JOB_RESET, 16'h0, srb_pkg::ERR_CMD);
    chk("no restart", n_restart - n0, 32'h0);
    rdr.send(2, 8'h40, 1'b0, 0);
    wait_flag();
    wr(srb_pkg::OFF_JOB_PARAMETER_BLOCK, 32'h020a);
    job(srb_pkg::JOB_RESET, 16'h0, srb_pkg::ERR_NONE);
    chk("restart", n_restart - n0, 32'h1);
    chk("emptied", 32'(data_present_flag), 32'h0);
    wr(srb_pkg::OFF_JOB_PARAMETER_BLOCK, 32'h000a);
    job(srb_pkg::JOB_RESET, 16'h0, srb_pkg::ERR_NONE);
  endtask

  // slow reader, data held before the read starts
  task automatic t_read();
    rdr.send(3, 8'ha0, 1'b0, 2);
    wait_flag();
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN, srb_pkg::ERR_NONE);
    chk("present cleared", 32'(data_present_flag), 32'h0);
    rd(srb_pkg::OFF_RESLEN, v);
    chk("length", v, 32'h3);
    for (int i = 0; i < 5; i++) begin
      rd(srb_pkg::OFF_RXDATA, v);
      chk("rx data", v, i == 0 ? 0 : i == 1 ? 3 : 32'h9e + i);
    end
  endtask

  task automatic t_pending();
    start(srb_pkg::JOB_READ, srb_pkg::ADDR_RAW);
    rd(srb_pkg::OFF_STATUS, v);
    chk("waiting", 32'(v[srb_pkg::STB_BUSY]), 32'h1);
    rdr.send(2, 8'hb0, 1'b0, 0);
    finish(srb_pkg::ERR_NONE);
    rd(srb_pkg::OFF_RXDATA, v);
    chk("raw byte 0", v, 32'hb0);
    rd(srb_pkg::OFF_RXDATA, v);
    chk("raw byte 1", v, 32'hb1);
  endtask

  task automatic t_cancel();
    start(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN);
    start(srb_pkg::JOB_WCFG, srb_pkg::ADDR_LEN);
    finish(srb_pkg::ERR_NONE);
    start(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN);
    start(srb_pkg::JOB_INIT, srb_pkg::ADDR_LEN);
    finish(srb_pkg::ERR_ABORT);
    start(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN);
    @(posedge clock);
    bus_unplugged <= 1'b1;
    @(posedge clock);
    bus_unplugged <= 1'b0;
    finish(srb_pkg::ERR_ABORT);
  endtask

  task automatic t_errors();
    job(srb_pkg::JOB_READ, 16'h0001, srb_pkg::ERR_ADDR);
    job(srb_pkg::JOB_WRITE, srb_pkg::ADDR_RAW, srb_pkg::ERR_CMD);
    for (int k = 5; k < 8; k++) begin
      job(3'(k), srb_pkg::ADDR_LEN, srb_pkg::ERR_CMD);
    end
    wr(srb_pkg::OFF_BLK_NUM, 32'h2);
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN, srb_pkg::ERR_BLK_NUM);
    wr(srb_pkg::OFF_BLK_NUM, 32'h0);
    @(posedge clock);
    comm_fail <= 1'b1;
    @(posedge clock);
    comm_fail <= 1'b0;
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN, srb_pkg::ERR_COMM);
    rdr.send(2, 8'hc0, 1'b1, 0);
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN, srb_pkg::ERR_NAK);
    rdr.send(1, 8'hd0, 1'b0, 0);
    wait_flag();
    rdr.send(1, 8'hd1, 1'b0, 0);
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN, srb_pkg::ERR_OVF);
    job(srb_pkg::JOB_INIT, 16'h0, srb_pkg::ERR_NONE);
  endtask

  // seventeen bytes into a fifteen byte buffer lose the two oldest
  task automatic t_wrap();
    rdr.send(17, 8'h10, 1'b0, 0);
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_RAW, srb_pkg::ERR_NONE);
    rd(srb_pkg::OFF_RXDATA, v);
    chk("oldest kept", v, 32'h12);
    rd(srb_pkg::OFF_RESLEN, v);
    chk("wrap length", v, 32'hf);
  endtask

  task automatic t_write();
    job(srb_pkg::JOB_INIT, 16'h0, srb_pkg::ERR_NONE);
    job(srb_pkg::JOB_WRITE, srb_pkg::ADDR_SEND, srb_pkg::ERR_NONE);
    rd(srb_pkg::OFF_STATUS, v);
    chk("write mode", 32'(v[srb_pkg::STB_WMODE]), 32'h1);
    wr(srb_pkg::OFF_TX, 32'h011);
    wr(srb_pkg::OFF_TX, 32'h122);
    repeat (2) @(posedge clock);
    chk("tx bytes", rdr.tx_count, 32'h2);
    chk("tx last", 32'(rdr.tx_last_byte), 32'h22);
    rdr.send(2, 8'he0, 1'b0, 0);
    wait_flag();
    rdr.send(3, 8'he8, 1'b0, 0);
    repeat (3) @(posedge clock);
    job(srb_pkg::JOB_READ, srb_pkg::ADDR_LEN, srb_pkg::ERR_NONE);
    rd(srb_pkg::OFF_RXDATA, v);
    rd(srb_pkg::OFF_RXDATA, v);
    chk("newest length", v, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_init();
    t_reset();
    t_read();
    t_pending();
    t_cancel();
    t_errors();
    t_wrap();
    t_write();
    end_of_test();
  end
endmodule
